//--- core/trf_byte_coder.sv
// Combinational coder from a raw result to integer and fraction bytes.
`timescale 1ns/10ps
module trf_byte_coder (
	input  wire logic [trf_pkg::TRF_RAW_W-1:0]  raw,
	input  wire logic                           ext_range,
	output logic      [trf_pkg::TRF_BYTE_W-1:0] hi_byte,
	output logic      [trf_pkg::TRF_BYTE_W-1:0] lo_byte
);
	import trf_pkg::*;

	logic signed [11:0] whole;
	logic signed [12:0] shifted;

	// Integer part is floor of raw/16, so the fraction is always non-negative.
	always_comb begin
		whole   = raw[15:4];                                         // R01
		shifted = {whole[11], whole} + {1'b0, TRF_EXT_OFFSET};       // R06
		if (ext_range) begin
			if (shifted < 0)
				hi_byte = 8'h00;                                 // R07
			else if (shifted > 13'sh0FF)
				hi_byte = TRF_EXT_MAX;                           // R07
			else
				hi_byte = shifted[7:0];                          // R06 R08
		end else begin
			if (whole < 0)
				hi_byte = TRF_STD_MIN;                           // R02
			else if (whole > 12'sh07F)
				hi_byte = TRF_STD_MAX;                           // R03
			else
				hi_byte = whole[7:0];                            // R08
		end
		// Below zero in standard range the whole value reads zero, fraction too.
		if (!ext_range && whole < 0)
			lo_byte = TRF_LO_RESET;                                  // R02
		else if (!ext_range && whole > 12'sh07F)
			lo_byte = TRF_LO_RESET;                                  // R03
		else
			lo_byte = {raw[3:0], TRF_LO_PAD};                        // R09
	end
endmodule : trf_byte_coder

//--- core/trf_formatter.sv
// Temperature result formatter: stores coded local and remote results.
// Functional notes
// R01: Results carry 12-bit precision, sixteenth-degree steps.
// R02: Standard range stores negatives as zero.
// R03: Standard range saturates above 127 at 7Fh.
// R04: Configuration bit 2 high selects extended coding.
// R05: Range change applies from next conversion only.
// R06: Extended integer byte is temperature plus 64.
// R07: Extended span clamps at minus 64 and 191.
// R08: Integer byte weighs one degree per count.
// R09: Fraction nibble left-justified, low nibble zero.
// R10: Both bytes of a channel update together.
`timescale 1ns/10ps
module trf_formatter (
	input  wire logic                           sys_clk,
	input  wire logic                           rst,
	input  wire logic                           clk_en,
	input  wire logic [trf_pkg::TRF_BYTE_W-1:0] cfg_byte,
	input  wire logic                           conv_start,
	input  wire logic                           conv_done,
	input  wire trf_pkg::trf_chan_e             conv_chan,
	input  wire logic [trf_pkg::TRF_RAW_W-1:0]  conv_raw,
	output logic      [trf_pkg::TRF_BYTE_W-1:0] local_hi,
	output logic      [trf_pkg::TRF_BYTE_W-1:0] local_lo,
	output logic      [trf_pkg::TRF_BYTE_W-1:0] remote_hi,
	output logic      [trf_pkg::TRF_BYTE_W-1:0] remote_lo,
	output logic                                ext_active
);
	import trf_pkg::*;

	logic       range_r;
	logic       range_nxt;
	logic [7:0] lh_r, ll_r, rh_r, rl_r;
	logic [7:0] lh_nxt, ll_nxt, rh_nxt, rl_nxt;
	logic [7:0] code_hi;
	logic [7:0] code_lo;

	// Lets one check cover both channels by picking the byte that the done pulse
	// addressed. A channel mix-up in the store path then shows as a mismatch.
	function automatic logic [7:0] trf_pick(
		input trf_chan_e  ch,
		input logic [7:0] loc,
		input logic [7:0] rem
	);
		return (ch == TRF_CH_LOCAL) ? loc : rem;
	endfunction : trf_pick

	// The range in force is latched at conversion start, so a change made
	// mid-conversion cannot mix codings within one stored result.
	always_comb begin
		range_nxt = range_r;
		if (conv_start)
			range_nxt = cfg_byte[TRF_CFG_RANGE_BIT];                 // R04 R05
	end

	trf_byte_coder u_coder (
		.raw       (conv_raw),
		.ext_range (range_r),
		.hi_byte   (code_hi),
		.lo_byte   (code_lo)
	);

	// Stored bytes change only when a conversion of that channel completes.
	always_comb begin
		lh_nxt = lh_r;
		ll_nxt = ll_r;
		rh_nxt = rh_r;
		rl_nxt = rl_r;
		if (conv_done) begin
			if (conv_chan == TRF_CH_LOCAL) begin
				lh_nxt = code_hi;                                // R10
				ll_nxt = code_lo;                                // R10
			end else begin
				rh_nxt = code_hi;                                // R10
				rl_nxt = code_lo;                                // R10
			end
		end
	end

	// Range register; the clock enable freezes it while low.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			range_r <= TRF_RANGE_RESET;
		end else if (clk_en) begin
			range_r <= range_nxt;                                    // R05
		end
	end

	// Result byte registers. A done pulse that arrives while the clock enable
	// is low is dropped, not stored late, so a frozen block never shows a
	// result out of order with the conversions that produced it.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lh_r <= TRF_HI_RESET;
			ll_r <= TRF_LO_RESET;
			rh_r <= TRF_HI_RESET;
			rl_r <= TRF_LO_RESET;
		end else if (clk_en) begin
			lh_r <= lh_nxt;                                          // R10
			ll_r <= ll_nxt;                                          // R10
			rh_r <= rh_nxt;                                          // R10
			rl_r <= rl_nxt;                                          // R10
		end
	end

	assign local_hi   = lh_r;
	assign local_lo   = ll_r;
	assign remote_hi  = rh_r;
	assign remote_lo  = rl_r;
	assign ext_active = range_r;

	// Checks next to the logic.
	a_std_clamp_hi : assert property (@(posedge sys_clk) disable iff (rst) // R03
		(clk_en && conv_done && !range_r && !conv_raw[15] && conv_raw[14:4] > 11'h07F
		 && conv_chan == TRF_CH_LOCAL) |=> local_hi == 8'h7F) // R03
		else $error("Standard range did not saturate at 7Fh.");
	a_std_clamp_lo : assert property (@(posedge sys_clk) disable iff (rst) // R02
		(clk_en && conv_done && !range_r && conv_raw[15] && conv_chan == TRF_CH_REMOTE)
		|=> remote_hi == 8'h00) // R02
		else $error("Negative standard result not stored as zero.");
	a_ext_offset : assert property (@(posedge sys_clk) disable iff (rst) // R06
		(clk_en && conv_done && range_r && conv_raw[15:4] == 12'h000
		 && conv_chan == TRF_CH_LOCAL) |=> local_hi == 8'h40) // R06
		else $error("Zero degrees in extended range not coded 40h.");
	a_ext_top : assert property (@(posedge sys_clk) disable iff (rst) // R07
		(clk_en && conv_done && range_r && !conv_raw[15] && conv_raw[14:4] > 11'h0BF
		 && conv_chan == TRF_CH_REMOTE) |=> remote_hi == 8'hFF) // R07
		else $error("Extended range did not clamp at FFh.");
	a_frac_nibble : assert property (@(posedge sys_clk) disable iff (rst) // R09
		local_lo[3:0] == 4'h0 && remote_lo[3:0] == 4'h0) // R09
		else $error("Fraction byte low nibble not zero.");
	a_frac_value : assert property (@(posedge sys_clk) disable iff (rst) // R09
		(clk_en && conv_done && range_r && conv_chan == TRF_CH_LOCAL)
		|=> local_lo[7:4] == $past(conv_raw[3:0])) // R01
		else $error("Fraction nibble not taken from result.");
	a_range_hold : assert property (@(posedge sys_clk) disable iff (rst) // R05
		(clk_en && !conv_start) |=> $stable(ext_active)) // R05
		else $error("Range changed outside a conversion start.");
	a_range_take : assert property (@(posedge sys_clk) disable iff (rst) // R04
		(clk_en && conv_start) |=> ext_active == $past(cfg_byte[2])) // R04
		else $error("Range select not taken at conversion start.");
	a_bytes_hold : assert property (@(posedge sys_clk) disable iff (rst) // R10
		(!(clk_en && conv_done)) |=> $stable(local_hi) && $stable(local_lo)
		&& $stable(remote_hi) && $stable(remote_lo)) // R10
		else $error("Stored result changed without a conversion.");
	a_std_weight : assert property (@(posedge sys_clk) disable iff (rst) // R08
		(clk_en && conv_done && !range_r && conv_raw[15:11] == 5'h00
		 && conv_chan == TRF_CH_REMOTE) |=> remote_hi == $past(conv_raw[11:4])) // R08
		else $error("Standard integer byte weight wrong.");

	// Steps of a conversion as the checks see them: a start that latches the
	// range, then in the next cycle the done pulse that stores the bytes.
	sequence s_start_std;
		clk_en && conv_start && !cfg_byte[TRF_CFG_RANGE_BIT];
	endsequence
	sequence s_start_ext;
		clk_en && conv_start && cfg_byte[TRF_CFG_RANGE_BIT];
	endsequence
	sequence s_done_zero;
		clk_en && conv_done && !conv_start && conv_raw[15:4] == 12'h000;
	endsequence
	sequence s_done_neg;
		clk_en && conv_done && !conv_start && conv_raw[15];
	endsequence
	// Start and done in one cycle: the done must still be coded in the old
	// range, since the new one only applies from the next conversion.
	sequence s_both_std_neg;
		clk_en && conv_start && conv_done && !range_r && conv_raw[15];
	endsequence
	sequence s_both_ext_m16;
		clk_en && conv_start && conv_done && range_r && conv_raw[15:4] == 12'hFF0;
	endsequence

	// A range chosen at start governs the done that follows it.
	a_next_ext_zero : assert property (@(posedge sys_clk) disable iff (rst) // R04 R05 R06
		s_start_ext ##1 s_done_zero
		|=> trf_pick($past(conv_chan), local_hi, remote_hi) == 8'h40)
		else $error("Extended range not applied from the next conversion.");
	a_next_std_neg : assert property (@(posedge sys_clk) disable iff (rst) // R02 R05
		s_start_std ##1 s_done_neg
		|=> trf_pick($past(conv_chan), local_hi, remote_hi) == 8'h00
		&& trf_pick($past(conv_chan), local_lo, remote_lo) == 8'h00)
		else $error("Negative standard result not cleared in both bytes.");
	a_both_std_old : assert property (@(posedge sys_clk) disable iff (rst) // R05
		s_both_std_neg |=> trf_pick($past(conv_chan), local_hi, remote_hi) == 8'h00)
		else $error("Done beside a start did not keep the standard range.");
	a_both_ext_old : assert property (@(posedge sys_clk) disable iff (rst) // R05 R06
		s_both_ext_m16 |=> trf_pick($past(conv_chan), local_hi, remote_hi) == 8'h30)
		else $error("Done beside a start did not keep the extended range.");

	// Stored results of the other channel stay untouched, the range holds while the clock enable is low; the addressed channel takes both bytes.
	a_local_kept : assert property (@(posedge sys_clk) disable iff (rst) // R05
		(clk_en && conv_done && conv_chan == TRF_CH_REMOTE)
		|=> $stable(local_hi) && $stable(local_lo))
		else $error("Local result changed by a remote conversion.");
	a_remote_kept : assert property (@(posedge sys_clk) disable iff (rst) // R05
		(clk_en && conv_done && conv_chan == TRF_CH_LOCAL)
		|=> $stable(remote_hi) && $stable(remote_lo))
		else $error("Remote result changed by a local conversion.");
	a_freeze_range : assert property (@(posedge sys_clk) disable iff (rst) // R05
		!clk_en |=> $stable(ext_active))
		else $error("Range changed while the clock enable was low.");
	a_pair_write : assert property (@(posedge sys_clk) disable iff (rst) // R10
		(clk_en && conv_done)
		|=> trf_pick($past(conv_chan), local_hi, remote_hi) == $past(code_hi)
		&& trf_pick($past(conv_chan), local_lo, remote_lo) == $past(code_lo))
		else $error("Result bytes of one channel not written together.");

	// Not disabled by reset: it checks what reset itself leaves behind.
	a_reset_clear : assert property (@(posedge sys_clk) // R10
		rst |=> local_hi == TRF_HI_RESET && local_lo == TRF_LO_RESET
		&& remote_hi == TRF_HI_RESET && remote_lo == TRF_LO_RESET && !ext_active)
		else $error("Reset did not clear the stored results.");

	// Clamp end points and the fraction byte in both ranges, either channel.
	a_ext_bottom : assert property (@(posedge sys_clk) disable iff (rst) // R07
		(clk_en && conv_done && range_r && conv_raw[15] && conv_raw[14:4] <= 11'h7C0)
		|=> trf_pick($past(conv_chan), local_hi, remote_hi) == 8'h00)
		else $error("Extended range did not clamp at minus 64.");
	a_std_frac : assert property (@(posedge sys_clk) disable iff (rst) // R09
		(clk_en && conv_done && !range_r && conv_raw[15:11] == 5'h00)
		|=> trf_pick($past(conv_chan), local_lo, remote_lo) == {$past(conv_raw[3:0]), 4'h0})
		else $error("Standard fraction byte not left-justified.");
	a_ext_frac_top : assert property (@(posedge sys_clk) disable iff (rst) // R07 R09
		(clk_en && conv_done && range_r && !conv_raw[15] && conv_raw[14:4] > 11'h0BF)
		|=> trf_pick($past(conv_chan), local_lo, remote_lo) == {$past(conv_raw[3:0]), 4'h0})
		else $error("Extended clamp at the top lost the fraction.");
endmodule : trf_formatter

//--- core/trf_pkg.sv
// Package of constants for the temperature result formatter.
package trf_pkg;
	// Raw conversion result: signed, one count is one sixteenth of a degree.
	localparam int unsigned TRF_RAW_W      = 16;
	localparam int unsigned TRF_PREC_BITS  = 12;
	localparam int unsigned TRF_FRAC_BITS  = 4;
	localparam int unsigned TRF_BYTE_W     = 8;
	// Integer byte codes and range limits in whole degrees.
	localparam logic [7:0]  TRF_STD_MIN    = 8'h00;
	localparam logic [7:0]  TRF_STD_MAX    = 8'h7F;
	localparam logic [11:0] TRF_EXT_OFFSET = 12'h040;
	localparam logic [7:0]  TRF_EXT_MAX    = 8'hFF;
	localparam logic [7:0]  TRF_HI_RESET   = 8'h00;
	localparam logic [7:0]  TRF_LO_RESET   = 8'h00;
	localparam logic [3:0]  TRF_LO_PAD     = 4'h0;
	// Position of the range select bit in the configuration byte.
	localparam int unsigned TRF_CFG_RANGE_BIT = 2;
	localparam logic        TRF_RANGE_RESET   = 1'b0;
	// Channel selection on the conversion result port.
	typedef enum logic [0:0] {
		TRF_CH_LOCAL  = 1'b0,
		TRF_CH_REMOTE = 1'b1
	} trf_chan_e;
endpackage : trf_pkg

//--- test/trf_formatter_tb_top.sv
// Self-checking bench for the temperature result formatter.
`timescale 1ns/10ps
module trf_formatter_tb_top;
	import trf_pkg::*;
	logic        sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, conv_start = 1'b0, conv_done = 1'b0;
	logic [7:0]  cfg_byte = 8'h00, local_hi, local_lo, remote_hi, remote_lo;
	trf_chan_e   conv_chan = TRF_CH_LOCAL;
	logic [15:0] conv_raw = 16'h0000, host_word, got;
	logic        ext_active, pend = 1'b0;
	logic [16:0] exp_q[$], e;
	logic        last_ext = 1'b0;
	logic [16:0] last_w[2] = '{17'h00000, 17'h10000};
	logic [15:0] vals[9] = '{16'hFC00, 16'hFBF0, 16'hFFF8, 16'h0008, 16'h07F0,
		16'h07FF, 16'h0800, 16'h0BF0, 16'h0C00};
	int          seed, error_cnt = 0, n_tests = 0, cyc = 0, r;
	trf_formatter u_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .cfg_byte(cfg_byte),
		.conv_start(conv_start), .conv_done(conv_done), .conv_chan(conv_chan),
		.conv_raw(conv_raw), .local_hi(local_hi), .local_lo(local_lo), .remote_hi(remote_hi),
		.remote_lo(remote_lo), .ext_active(ext_active));
	trf_host_model u_host (.sys_clk(sys_clk), .rd_req(1'b1), .hi_in(remote_hi),
		.lo_in(remote_lo), .rd_word(host_word));
	// The clock runs at 40 MHz.
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] sn);
		n_tests++;
		if (sn !== ex) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, ex, sn);
		end
	endtask : check
	// Expected bytes are built from the coding rules, not from the design.
	function automatic logic [16:0] expect_f(input logic ext, input logic c, input logic [15:0] w);
		int         i;
		logic [7:0] l;
		i = $signed(w[15:4]);
		l = {w[3:0], 4'h0};
		if (ext) begin
			i = i + 64;
			i = (i < 0) ? 0 : ((i > 255) ? 255 : i);
		end else if (i < 0 || i > 127) begin
			i = (i < 0) ? 0 : 127;
			l = 8'h00;
		end
		return {c, i[7:0], l};
	endfunction : expect_f
	// One conversion; the range bit is flipped after start to show it is ignored.
	task automatic conv(input logic ext, input logic c, input logic [15:0] w);
		@(negedge sys_clk);
		conv_start = 1'b1;
		cfg_byte = 8'($random(seed));
		cfg_byte[2] = ext;
		@(negedge sys_clk);
		conv_start = 1'b0;
		cfg_byte[2] = ~ext;
		check("ext_active", 32'(ext), 32'(ext_active));
		conv_done = 1'b1;
		conv_chan = trf_chan_e'(c);
		conv_raw = w;
		last_w[c] = expect_f(ext, c, w);
		last_ext = ext;
		exp_q.push_back(last_w[c]);
		@(negedge sys_clk);
		conv_done = 1'b0;
	endtask : conv
	// Start and done in one cycle: the done is coded in the range in force.
	// With the clock enable low the design must drop both and keep its state.
	task automatic same_cycle(input logic en, input logic c, input logic [15:0] w);
		logic [16:0] x;
		x = en ? expect_f(last_ext, c, w) : last_w[c];
		@(negedge sys_clk);
		clk_en = en;
		conv_start = 1'b1;
		cfg_byte[2] = ~last_ext;
		conv_done = 1'b1;
		conv_chan = trf_chan_e'(c);
		conv_raw = w;
		exp_q.push_back(x);
		@(negedge sys_clk);
		clk_en = 1'b1;
		conv_start = 1'b0;
		conv_done = 1'b0;
		last_w[c] = x;
		if (en) last_ext = ~last_ext;
		check("range", 32'(last_ext), 32'(ext_active));
	endtask : same_cycle
	task automatic final_report();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	// Scoreboard: a stored result appears one cycle after its done pulse.
	always @(posedge sys_clk) begin
		if (pend) begin
			e = exp_q.pop_front();
			got = e[16] ? {remote_hi, remote_lo} : {local_hi, local_lo};
			check(e[16] ? "remote" : "local", 32'(e[15:0]), 32'(got));
		end
		pend <= conv_done;
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			final_report();
		end
	end
	// Boundary table in both ranges and channels, then random temperatures.
	initial begin
		seed = 65;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		check("reset", 32'h0, {local_hi, local_lo, remote_hi, remote_lo});
		check("reset range", 32'h0, 32'(ext_active));
		for (int k = 0; k < 36; k++) conv(k[0], k[1], vals[k % 9]);
		repeat (60) begin
			r = $random(seed);
			conv(r[0], r[1], {{2{r[15]}}, r[15:2]});
		end
		for (int k = 0; k < 4; k++) same_cycle(k[1], k[0], k[1] ? 16'hFF00 : 16'($random(seed)));
		repeat (2) @(negedge sys_clk);
		check("host", 32'({remote_hi, remote_lo}), 32'(host_word));
		final_report();
	end
endmodule : trf_formatter_tb_top

//--- test/trf_host_model.sv
// Host side model that snapshots one channel's stored result bytes on a read request.
`timescale 1ns/10ps
module trf_host_model (
	input  wire logic        sys_clk,
	input  wire logic        rd_req,
	input  wire logic [7:0]  hi_in,
	input  wire logic [7:0]  lo_in,
	output logic      [15:0] rd_word
);
	// Both bytes are taken in one edge, so a read never mixes two conversions.
	always_ff @(posedge sys_clk) begin
		if (rd_req) begin
			rd_word <= {hi_in, lo_in};
		end
	end
endmodule : trf_host_model
